// File: rtl/tdm_drive_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - drive enable low: outputs high or tristate
// - drive enable high: outputs carry stream data
// - drive enable gates outputs without clocking
// - backplane strap low: start high, stay active
// - backplane strap high: start tristate, enable-controlled
// - backplane per-channel enable bit gates drive
// - local strap low: start high, stay active
// - local strap high: start tristate, enable-controlled
// - local per-channel enable bit gates drive
// - sixteen backplane streams, 512 channels each
// - sixteen local streams, 512 channels each
// - fifteen-bit host address, bit zero lsb
// - sixteen-bit two-way host data bus
// - host selects port with select low
// - host waits 30 ns after acknowledge
// - strobe with select starts an access
// - acknowledge low marks transfer done
// - read/write sets direction; device drives reads
// - reset holds outputs per strap, clears state
module tdm_drive_dev (
    input  wire logic                                   i_clk,
    input  wire logic                                   i_reset,
    input  wire logic                                   i_link_clk,
    input  wire logic                                   i_frame_n,
    input  wire logic                                   i_output_drive_enable,
    input  wire logic                                   i_bp_output_reset_strap,
    input  wire logic                                   i_loc_output_reset_strap,
    output logic      [tdm_drive_pkg::N_STREAMS-1:0]    o_backplane_serial_out,
    output logic      [tdm_drive_pkg::N_STREAMS-1:0]    o_backplane_serial_oe,
    output logic      [tdm_drive_pkg::N_STREAMS-1:0]    o_local_serial_out,
    output logic      [tdm_drive_pkg::N_STREAMS-1:0]    o_local_serial_oe,
    tdm_drive_if.dev                                    hp
);
    import tdm_drive_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } port_state_t;

    localparam int PIN_W = 3 + ADDR_W + DATA_W;

    function automatic logic [ENTRY_IDX_W-1:0] entry_idx(input logic [STREAM_W-1:0] s,
                                                         input logic [CHAN_W-1:0]   c);
        entry_idx = {s, c};
    endfunction

    // returns {pin level, output enable}
    function automatic logic [1:0] pin_drive(input logic hold, input logic strap_pin,
                                             input logic strap, input logic output_drive_enable,
                                             input logic chan_en, input logic bitv);
        if (hold) begin
            pin_drive = {1'b1, ~strap_pin};
        end else if (!strap) begin
            pin_drive = {output_drive_enable ? bitv : 1'b1, 1'b1};
        end else begin
            pin_drive = {bitv, output_drive_enable & chan_en};
        end
    endfunction

    // ==========================================
    // pin synchronisers
    logic [PIN_W-1:0]  pin_s1_q;
    logic [PIN_W-1:0]  pin_s2_q;
    logic [1:0]        strap_s1_q;
    logic [1:0]        strap_s2_q;
    logic [1:0]        lclk_s1_q;
    logic [2:1]        lclk_q;
    logic              fr_s1_q;
    logic              fr_s2_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_s1_q   <= '1;
            pin_s2_q   <= '1;
            lclk_s1_q  <= 2'h0;
            lclk_q     <= 2'h0;
            fr_s1_q    <= 1'b1;
            fr_s2_q    <= 1'b1;
        end else begin
            pin_s1_q   <= {hp.cs_n, hp.strobe_n, hp.rd_wr, hp.host_addr_bus, hp.host_data_bus};
            pin_s2_q   <= pin_s1_q;
            lclk_s1_q  <= {lclk_s1_q[0], i_link_clk};
            lclk_q     <= {lclk_q[1], lclk_s1_q[1]};
            fr_s1_q    <= i_frame_n;
            fr_s2_q    <= fr_s1_q;
        end
    end

    // strap pins keep moving through reset, else the capture would see the reset zeros
    always_ff @(posedge i_clk) begin
        strap_s1_q <= {i_loc_output_reset_strap, i_bp_output_reset_strap};
        strap_s2_q <= strap_s1_q;
    end

    logic              sel_n;
    logic              stb_n;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              link_rise;
    assign {sel_n, stb_n, rd, addr, wdata} = pin_s2_q;
    assign link_rise = lclk_q[1] & ~lclk_q[2];

    // ==========================================
    // strap capture after reset release
    logic [1:0] strap_q;
    logic [1:0] strap_d;
    logic [1:0] settle_q;
    logic [1:0] settle_d;
    logic       settled;
    assign settled = (settle_q == 2'(STRAP_SETTLE_CYC));

    always_comb begin
        settle_d = settled ? settle_q : settle_q + 2'h1;
        strap_d  = settled ? strap_q : strap_s2_q;      // held once captured
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            settle_q <= 2'h0;
            strap_q  <= 2'h0;
        end else begin
            settle_q <= settle_d;
            strap_q  <= strap_d;
        end
    end

    // ==========================================
    // connection memories, side 0 backplane, side 1 local
    logic [ENTRY_W-1:0] cm_q [2][N_ENTRIES];
    logic               cm_we;
    logic [ENTRY_W-1:0] cm_wdata;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int s = 0; s < 2; s++) begin
                for (int e = 0; e < N_ENTRIES; e++) begin
                    cm_q[s][e] <= ENTRY_RESET;
                end
            end
        end else if (cm_we) begin
            cm_q[addr[SIDE_BIT]][addr[ENTRY_IDX_W-1:0]] <= cm_wdata;
        end
    end

    // ==========================================
    // host port
    port_state_t       st_q;
    port_state_t       st_d;
    logic              rd_q;
    logic              rd_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    always_comb begin
        st_d     = st_q;
        rd_d     = rd_q;
        rdata_d  = rdata_q;
        cm_we    = 1'b0;
        cm_wdata = wdata[ENTRY_W-1:0];
        unique case (st_q)
            ST_IDLE: begin
                if (!sel_n && !stb_n) begin
                    rd_d = rd;
                    if (rd) begin
                        rdata_d = {{(DATA_W-ENTRY_W){1'b0}},
                                   cm_q[addr[SIDE_BIT]][addr[ENTRY_IDX_W-1:0]]};
                    end else begin
                        cm_we = 1'b1;
                    end
                    st_d = ST_ACK;
                end
            end
            ST_ACK: begin
                if (sel_n || stb_n) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q    <= ST_IDLE;
            rd_q    <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            st_q    <= st_d;
            rd_q    <= rd_d;
            rdata_q <= rdata_d;
        end
    end

    assign hp.ack_drv     = 1'b0;
    assign hp.ack_oe      = (st_q == ST_ACK);
    assign hp.dev_data_oe = (st_q == ST_ACK) && rd_q;
    assign hp.dev_rdata   = rdata_q;

    // ==========================================
    // frame timing and per-stream shifters
    logic [BIT_CNT_W-1:0] bit_q;
    logic [BIT_CNT_W-1:0] bit_d;
    logic [BYTE_W-1:0]    sh_q [2][N_STREAMS];
    logic [BYTE_W-1:0]    sh_d [2][N_STREAMS];
    logic [N_STREAMS-1:0] en_q [2];
    logic [N_STREAMS-1:0] en_d [2];
    logic [ENTRY_W-1:0]   ent;

    always_comb begin
        bit_d = bit_q;
        sh_d  = sh_q;
        en_d  = en_q;
        ent   = ENTRY_RESET;
        if (link_rise) begin
            bit_d = !fr_s2_q ? '0 : bit_q + 12'h001;
            for (int s = 0; s < 2; s++) begin
                for (int i = 0; i < N_STREAMS; i++) begin
                    if (bit_d[2:0] == 3'h0) begin
                        // reload at each timeslot start so the enable tracks its channel
                        ent        = cm_q[s][entry_idx(STREAM_W'(i), bit_d[BIT_CNT_W-1:3])];
                        sh_d[s][i] = ent[BYTE_W-1:0];
                        en_d[s][i] = ent[EN_BIT];
                    end else begin
                        sh_d[s][i] = {sh_q[s][i][BYTE_W-2:0], 1'b1};
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            bit_q <= '0;
            for (int s = 0; s < 2; s++) begin
                en_q[s] <= 16'h0000;
                for (int i = 0; i < N_STREAMS; i++) begin
                    sh_q[s][i] <= 8'hff;
                end
            end
        end else begin
            bit_q <= bit_d;
            sh_q  <= sh_d;
            en_q  <= en_d;
        end
    end

    // ==========================================
    // output drive; enable pin is not synchronised on purpose, it must act at once
    always_comb begin
        for (int i = 0; i < N_STREAMS; i++) begin
            {o_backplane_serial_out[i], o_backplane_serial_oe[i]} =
                pin_drive(i_reset | ~settled, i_bp_output_reset_strap, strap_q[0],
                          i_output_drive_enable, en_q[0][i], sh_q[0][i][BYTE_W-1]);
            {o_local_serial_out[i], o_local_serial_oe[i]} =
                pin_drive(i_reset | ~settled, i_loc_output_reset_strap, strap_q[1],
                          i_output_drive_enable, en_q[1][i], sh_q[1][i][BYTE_W-1]);
        end
    end
endmodule
`default_nettype wire

// File: rtl/tdm_drive_pkg.sv
package tdm_drive_pkg;
    // ==========================================
    // host port geometry
    localparam int ADDR_W      = 15;
    localparam int DATA_W      = 16;
    localparam int SIDE_BIT    = 14;
    localparam int ENTRY_IDX_W = 13;
    // ==========================================
    // serial streams
    localparam int N_STREAMS   = 16;
    localparam int STREAM_W    = 4;
    localparam int N_CHANS     = 512;
    localparam int CHAN_W      = 9;
    localparam int BYTE_W      = 8;
    localparam int BIT_CNT_W   = 12;
    localparam int N_ENTRIES   = N_STREAMS * N_CHANS;
    // ==========================================
    // connection memory entry: message byte plus drive enable
    localparam int ENTRY_W     = 9;
    localparam int EN_BIT      = 8;
    localparam logic [ENTRY_W-1:0] ENTRY_RESET = 9'h000;
    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS    = 10;
    localparam int HOST_GAP_NS      = 30;
    localparam int HOST_GAP_CYC     = (HOST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_SETTLE_CYC = 2;
endpackage

// File: rtl/tdm_drive_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tdm_drive_if;
    import tdm_drive_pkg::*;
    logic              cs_n;
    logic              strobe_n;
    logic              rd_wr;
    logic [ADDR_W-1:0] host_addr_bus;
    logic [DATA_W-1:0] host_wdata;
    logic              host_data_oe;
    logic [DATA_W-1:0] dev_rdata;
    logic              dev_data_oe;
    logic              ack_drv;
    logic              ack_oe;
    // ==========================================
    // resolved wires; undriven lines float high like a pull-up
    logic [DATA_W-1:0] host_data_bus;
    logic              transfer_ack_n;
    assign host_data_bus  = dev_data_oe ? dev_rdata : (host_data_oe ? host_wdata : 16'hffff);
    assign transfer_ack_n = ack_oe ? ack_drv : 1'b1;

    modport dev (input cs_n, strobe_n, rd_wr, host_addr_bus, host_data_bus,
                 output dev_rdata, dev_data_oe, ack_drv, ack_oe);
    modport host (input host_data_bus, transfer_ack_n,
                  output cs_n, strobe_n, rd_wr, host_addr_bus, host_wdata, host_data_oe);
endinterface
`default_nettype wire

// File: rtl/tdm_drive_host.sv
`timescale 1ns/1ps
`default_nettype none
module tdm_drive_host (
    input  wire logic                               i_clk,
    input  wire logic                               i_reset,
    input  wire logic                               i_req,
    input  wire logic                               i_rd,
    input  wire logic [tdm_drive_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [tdm_drive_pkg::DATA_W-1:0]   i_wdata,
    output logic                                    o_ready,
    output logic                                    o_done,
    output logic      [tdm_drive_pkg::DATA_W-1:0]   o_rdata,
    tdm_drive_if.host                               hp
);
    import tdm_drive_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_WAIT  = 5'b00100,
        ST_REL   = 5'b01000,
        ST_GAP   = 5'b10000
    } host_state_t;

    // ==========================================
    // acknowledge and data synchronisers
    logic [DATA_W:0] in_s1_q;
    logic [DATA_W:0] in_s2_q;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            in_s1_q <= '1;
            in_s2_q <= '1;
        end else begin
            in_s1_q <= {hp.transfer_ack_n, hp.host_data_bus};
            in_s2_q <= in_s1_q;
        end
    end

    logic ack_n;
    assign ack_n = in_s2_q[DATA_W];

    // ==========================================
    // access sequencer
    host_state_t       st_q;
    host_state_t       st_d;
    logic              rd_q;
    logic              rd_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] wd_q;
    logic [DATA_W-1:0] wd_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              done_q;
    logic              done_d;
    logic [1:0]        gap_q;
    logic [1:0]        gap_d;

    always_comb begin
        st_d    = st_q;
        rd_d    = rd_q;
        addr_d  = addr_q;
        wd_d    = wd_q;
        rdata_d = rdata_q;
        done_d  = 1'b0;
        gap_d   = gap_q;
        unique case (st_q)
            ST_IDLE: begin
                if (i_req) begin
                    // address and data settle a cycle ahead of select
                    rd_d   = i_rd;
                    addr_d = i_addr;
                    wd_d   = i_wdata;
                    st_d   = ST_SETUP;
                end
            end
            ST_SETUP: st_d = ST_WAIT;
            ST_WAIT: begin
                if (!ack_n) begin
                    rdata_d = rd_q ? in_s2_q[DATA_W-1:0] : rdata_q;
                    done_d  = 1'b1;
                    st_d    = ST_REL;
                end
            end
            ST_REL: begin
                if (ack_n) begin
                    gap_d = 2'h0;
                    st_d  = ST_GAP;
                end
            end
            ST_GAP: begin
                gap_d = gap_q + 2'h1;
                if (gap_q == 2'(HOST_GAP_CYC - 1)) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q    <= ST_IDLE;
            rd_q    <= 1'b1;
            addr_q  <= 15'h0000;
            wd_q    <= 16'h0000;
            rdata_q <= 16'h0000;
            done_q  <= 1'b0;
            gap_q   <= 2'h0;
        end else begin
            st_q    <= st_d;
            rd_q    <= rd_d;
            addr_q  <= addr_d;
            wd_q    <= wd_d;
            rdata_q <= rdata_d;
            done_q  <= done_d;
            gap_q   <= gap_d;
        end
    end

    assign hp.cs_n          = (st_q != ST_WAIT);
    assign hp.strobe_n      = (st_q != ST_WAIT);
    assign hp.rd_wr         = rd_q;
    assign hp.host_addr_bus = addr_q;
    assign hp.host_wdata    = wd_q;
    assign hp.host_data_oe  = !rd_q && (st_q == ST_SETUP || st_q == ST_WAIT);
    assign o_ready          = (st_q == ST_IDLE);
    assign o_done           = done_q;
    assign o_rdata          = rdata_q;
endmodule
`default_nettype wire

// File: tb/tdm_drive_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tdm_drive_sva (
    input wire logic                                i_clk,
    input wire logic                                i_reset,
    input wire logic                                cs_n,
    input wire logic                                strobe_n,
    input wire logic                                rd_wr,
    input wire logic                                host_data_oe,
    input wire logic                                dev_data_oe,
    input wire logic                                transfer_ack_n,
    input wire logic                                i_output_drive_enable,
    input wire logic                                i_bp_output_reset_strap,
    input wire logic                                i_loc_output_reset_strap,
    input wire logic [tdm_drive_pkg::N_STREAMS-1:0] o_backplane_serial_out,
    input wire logic [tdm_drive_pkg::N_STREAMS-1:0] o_backplane_serial_oe,
    input wire logic [tdm_drive_pkg::N_STREAMS-1:0] o_local_serial_out,
    input wire logic [tdm_drive_pkg::N_STREAMS-1:0] o_local_serial_oe
);
    import tdm_drive_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // ==========================================
    // drive control
    chk_ode_low_bp: assert property (!i_output_drive_enable |->
        o_backplane_serial_oe == (i_bp_output_reset_strap ? 16'h0000 : 16'hffff))
        else $error("backplane not parked while drive enable low");
    chk_ode_low_loc: assert property (!i_output_drive_enable |->
        o_local_serial_oe == (i_loc_output_reset_strap ? 16'h0000 : 16'hffff))
        else $error("local not parked while drive enable low");
    chk_park_high_bp: assert property (!i_output_drive_enable && !i_bp_output_reset_strap
        |-> o_backplane_serial_out == 16'hffff)
        else $error("backplane not high while parked");
    chk_strap0_bp_on: assert property (!i_bp_output_reset_strap |->
        o_backplane_serial_oe == 16'hffff)
        else $error("backplane released with strap low");
    chk_strap0_loc_on: assert property (!i_loc_output_reset_strap |->
        o_local_serial_oe == 16'hffff)
        else $error("local released with strap low");
    // ==========================================
    // host port handshake
    chk_ack_needs_sel: assert property ($fell(transfer_ack_n) |->
        !$past(cs_n, 2) && !$past(strobe_n, 2))
        else $error("acknowledge without select and strobe");
    chk_ack_in_time: assert property ($fell(strobe_n) && !cs_n |->
        ##[2:5] !transfer_ack_n)
        else $error("acknowledge late");
    chk_ack_drops: assert property ($rose(cs_n) |-> ##[1:4] transfer_ack_n)
        else $error("acknowledge stuck after release");
    chk_read_dir: assert property ($rose(dev_data_oe) |-> rd_wr && !host_data_oe)
        else $error("device drives data outside a read");
    chk_gap_wait: assert property ($rose(transfer_ack_n) |-> cs_n [*3])
        else $error("next select too soon after acknowledge");
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tdm_drive_pkg::*;
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 link_clk = 1'b0;
    logic                 frame_n = 1'b1;
    logic                 output_drive_enable = 1'b0;
    logic                 bp_strap = 1'b1;
    logic                 loc_strap = 1'b1;
    logic                 req = 1'b0;
    logic                 rd = 1'b0;
    logic [ADDR_W-1:0]    addr = 15'h0000;
    logic [DATA_W-1:0]    wdata = 16'h0000;
    logic                 ready;
    logic                 done;
    logic [DATA_W-1:0]    rdata;
    logic [N_STREAMS-1:0] bp_out;
    logic [N_STREAMS-1:0] bp_oe;
    logic [N_STREAMS-1:0] loc_out;
    logic [N_STREAMS-1:0] loc_oe;
    int                   fail_count = 0;
    int                   n_tests = 0;

    always #5 clk = ~clk;

    tdm_drive_if i_tdm_drive_if ();
    tdm_drive_dev i_tdm_drive_dev (.i_clk(clk), .i_reset(reset), .i_link_clk(link_clk),
        .i_frame_n(frame_n), .i_output_drive_enable(output_drive_enable), .i_bp_output_reset_strap(bp_strap),
        .i_loc_output_reset_strap(loc_strap), .o_backplane_serial_out(bp_out),
        .o_backplane_serial_oe(bp_oe), .o_local_serial_out(loc_out),
        .o_local_serial_oe(loc_oe), .hp(i_tdm_drive_if.dev));
    tdm_drive_host i_tdm_drive_host (.i_clk(clk), .i_reset(reset), .i_req(req), .i_rd(rd),
        .i_addr(addr), .i_wdata(wdata), .o_ready(ready), .o_done(done), .o_rdata(rdata),
        .hp(i_tdm_drive_if.host));
    tdm_drive_sva i_chk (.i_clk(clk), .i_reset(reset), .cs_n(i_tdm_drive_if.cs_n),
        .strobe_n(i_tdm_drive_if.strobe_n), .rd_wr(i_tdm_drive_if.rd_wr),
        .host_data_oe(i_tdm_drive_if.host_data_oe), .dev_data_oe(i_tdm_drive_if.dev_data_oe),
        .transfer_ack_n(i_tdm_drive_if.transfer_ack_n), .i_output_drive_enable(output_drive_enable),
        .i_bp_output_reset_strap(bp_strap), .i_loc_output_reset_strap(loc_strap),
        .o_backplane_serial_out(bp_out), .o_backplane_serial_oe(bp_oe),
        .o_local_serial_out(loc_out), .o_local_serial_oe(loc_oe));

    // ==========================================
    // shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // straps only move while reset holds, so the captured value matches the pin
    task automatic do_reset(input logic bs, input logic ls);
        reset = 1'b1;
        bp_strap = bs;
        loc_strap = ls;
        repeat (6) @(negedge clk);
        check(bp_out, 16'hffff);
        check(bp_oe, bs ? 16'h0000 : 16'hffff);
        check(loc_oe, ls ? 16'h0000 : 16'hffff);
        reset = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic access(input logic r, input logic [14:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        rd = r;
        addr = a;
        wdata = d;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        check({15'h0000, done}, 16'h0001);
    endtask

    // link clock only toggles inside frames; one bit per call
    task automatic link_bit(input logic f);
        frame_n = f;
        link_clk = 1'b1;
        repeat (8) @(negedge clk);
        link_clk = 1'b0;
        repeat (8) @(negedge clk);
    endtask

    // ==========================================
    // scenarios
    task automatic t_strap_low;
        do_reset(1'b0, 1'b0);
        output_drive_enable = 1'b1;
        link_bit(1'b0);
        check(bp_out, 16'h0000);
        check(loc_out, 16'h0000);
        check(loc_oe, 16'hffff);
        output_drive_enable = 1'b0;
        #1;
        check(bp_out, 16'hffff);
        check(loc_out, 16'hffff);
        output_drive_enable = 1'b1;
        $display("strap low test done");
    endtask

    task automatic t_host_port;
        do_reset(1'b1, 1'b1);
        access(1'b0, 15'h0600, 16'h01a5);
        access(1'b0, 15'h4a00, 16'hff3c);
        access(1'b1, 15'h0600, 16'h0000);
        check(rdata, 16'h01a5);
        access(1'b1, 15'h4a00, 16'h0000);
        check(rdata, 16'h013c);
        $display("host port test done");
    endtask

    task automatic t_chan_enable;
        logic [7:0] bb;
        logic [7:0] lb;
        bb = 8'ha5;
        lb = 8'h3c;
        output_drive_enable = 1'b1;
        for (int i = 0; i < 8; i++) begin
            link_bit(i != 0);
            check(bp_oe, 16'h0008);
            check(loc_oe, 16'h0020);
            check({15'h0000, bp_out[3]}, {15'h0000, bb[7-i]});
            check({15'h0000, loc_out[5]}, {15'h0000, lb[7-i]});
            if (i == 4) begin
                output_drive_enable = 1'b0;
                #1;
                check(bp_oe, 16'h0000);
                check(loc_oe, 16'h0000);
                output_drive_enable = 1'b1;
                #1;
                check(bp_oe, 16'h0008);
            end
        end
        link_bit(1'b1);
        check(bp_oe, 16'h0000);
        check(loc_oe, 16'h0000);
        $display("channel enable test done");
    endtask

    initial begin
        #300000;
        fail_count++;
        results();
    end

    initial begin
        t_strap_low();
        t_host_port();
        t_chan_enable();
        results();
    end
endmodule
`default_nettype wire
